//--- common/dram_seq_pkg.sv
package dram_seq_pkg;
  // Request command codes
  typedef enum logic [1:0] {
    CMD_NOP = 2'b00,
    CMD_ACT = 2'b01,
    CMD_COL = 2'b10,
    CMD_PRE = 2'b11
  } cmd_e;
  // Latencies and column cycle, in request clock cycles
  localparam int WRITE_DATA_DELAY = 3;
  localparam int READ_DATA_DELAY = 6;
  localparam int COLUMN_CYCLE_TIME = 2;
  // Reset values
  localparam logic ROW_OPEN_RST = 1'b0;
endpackage : dram_seq_pkg

//--- rtl/dram_fifo.sv
`timescale 1ns/1ps
module dram_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Sync reset, active low
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Word in
  output logic out_valid, // Word waiting
  input wire logic out_ready, // Drain accepts
  output logic [WIDTH-1:0] out_data // Head word
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be power of two");
  end
  logic [WIDTH-1:0] mem_r [DEPTH]; // Storage
  logic [AW-1:0] wp_r; // Write pointer
  logic [AW-1:0] rp_r; // Read pointer
  logic [AW:0] cnt_r; // Fill level
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_r != (AW+1)'(DEPTH)); // Full stops the source
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  // Pointers and level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // Storage has no reset; contents are undefined until written
  always_ff @(posedge clk) begin
    if (push) mem_r[wp_r] <= in_data;
  end
endmodule : dram_fifo

//--- rtl/dram_seq.sv
`timescale 1ns/1ps
module dram_seq import dram_seq_pkg::*; #(
  parameter int BANKS = 8,
  parameter int ROW_W = 12,
  parameter int COL_W = 6,
  parameter int DATA_W = 16
) (
  input wire logic clk, // Request clock
  input wire logic rst_n, // Sync reset, active low
  input wire logic [1:0] req_cmd, // Request packet command
  input wire logic [$clog2(BANKS)-1:0] req_bank, // Bank address
  input wire logic [ROW_W-1:0] req_row, // Row for activate
  input wire logic [COL_W-1:0] req_col, // Column for column packet
  input wire logic req_wr, // Column write when high, read when low
  input wire logic [DATA_W-1:0] wdata, // Write data bus
  output logic rd_valid_r, // Read data packet on bus
  output logic [DATA_W-1:0] rdata_r, // Read data bus
  output logic wr_valid_r, // Captured write word popped toward the core
  input wire logic wr_ready, // Core accepts captured write words
  output logic [DATA_W-1:0] wr_word_r, // Captured write word
  output logic [BANKS-1:0] row_open_r, // Bank holds a row
  output logic fifo_full_r // Capture buffer full
);
  localparam int BW = $clog2(BANKS);
  localparam int PIPE = READ_DATA_DELAY + COLUMN_CYCLE_TIME;
  initial begin
    if (BANKS < 2 || COL_W < 1) $error("bad geometry");
  end
  // Sense amp rows, one small array per bank, as column words
  logic [DATA_W-1:0] amp_r [BANKS][1<<COL_W]; // Open rows
  logic [ROW_W-1:0] row_addr_r [BANKS]; // Sensed row per bank
  logic [PIPE-1:0] rd_pipe_r; // Read command delay line
  logic [BW+COL_W-1:0] rd_adr_r [PIPE]; // Read address delay line
  logic [WRITE_DATA_DELAY:0] wr_pipe_r; // Write command delay line
  logic [BW+COL_W-1:0] wr_adr_r [WRITE_DATA_DELAY+1]; // Write address delay line
  logic [COLUMN_CYCLE_TIME-1:0] rd_len_r; // Read packet length count
  logic [COLUMN_CYCLE_TIME-1:0] wr_len_r; // Write packet length count
  cmd_e cmd;
  assign cmd = cmd_e'(req_cmd);
  // A lone column command between activate and precharge needs nothing special here
  wire is_act = (cmd == CMD_ACT);
  wire is_pre = (cmd == CMD_PRE);
  wire is_rd = (cmd == CMD_COL) && !req_wr;
  wire is_wr = (cmd == CMD_COL) && req_wr;
  wire [BW+COL_W-1:0] adr = {req_bank, req_col};
  // Head of the write line: data arrives now
  wire wr_due = wr_pipe_r[WRITE_DATA_DELAY-1];
  wire [BW-1:0] wr_bank = wr_adr_r[WRITE_DATA_DELAY-1][BW+COL_W-1:COL_W];
  wire [COL_W-1:0] wr_col = wr_adr_r[WRITE_DATA_DELAY-1][COL_W-1:0];
  wire rd_due = rd_pipe_r[READ_DATA_DELAY-1];
  wire [BW-1:0] rd_bank = rd_adr_r[READ_DATA_DELAY-1][BW+COL_W-1:COL_W];
  wire [COL_W-1:0] rd_col = rd_adr_r[READ_DATA_DELAY-1][COL_W-1:0];
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [DATA_W-1:0] fifo_out_data;
  // Open-row flags per bank; the controller owns hit/miss decisions
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      row_open_r <= {BANKS{ROW_OPEN_RST}};
    end else if (is_act) begin
      row_open_r[req_bank] <= 1'b1;
    end else if (is_pre) begin
      row_open_r[req_bank] <= 1'b0;
    end
  end
  // Row address latched at activate, kept for the row's life
  always_ff @(posedge clk) begin
    if (is_act) row_addr_r[req_bank] <= req_row;
  end
  // Command delay lines; a shift per cycle gives exact latency
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_pipe_r <= '0;
      wr_pipe_r <= '0;
    end else begin
      rd_pipe_r <= {rd_pipe_r[PIPE-2:0], is_rd};
      wr_pipe_r <= {wr_pipe_r[WRITE_DATA_DELAY-1:0], is_wr};
    end
  end
  always_ff @(posedge clk) begin
    rd_adr_r[0] <= adr;
    wr_adr_r[0] <= adr;
    for (int i = 1; i < PIPE; i++) rd_adr_r[i] <= rd_adr_r[i-1];
    for (int i = 1; i <= WRITE_DATA_DELAY; i++) wr_adr_r[i] <= wr_adr_r[i-1];
  end
  // Write data lands in the open row's sense amps at its slot
  always_ff @(posedge clk) begin
    if (wr_due && row_open_r[wr_bank]) amp_r[wr_bank][wr_col] <= wdata;
  end
  // Read data packet: starts read_data_delay after command, lasts a column cycle
  // rd_len_r holds the cycles still owed after the first one of the packet
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_valid_r <= 1'b0;
      rdata_r <= '0;
      rd_len_r <= '0;
    end else if (rd_due) begin
      // A new packet may follow the old one back to back
      rd_valid_r <= 1'b1;
      rdata_r <= amp_r[rd_bank][rd_col];
      rd_len_r <= COLUMN_CYCLE_TIME'(COLUMN_CYCLE_TIME - 1);
    end else if (rd_len_r != '0) begin
      // Packet still running: data held, count down
      rd_len_r <= rd_len_r - 1'b1;
    end else begin
      // Bus idle
      rd_valid_r <= 1'b0;
    end
  end
  // Write packet window tracker; only the wr_slot_a assertion reads it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_len_r <= '0;
    end else if (wr_due) begin
      wr_len_r <= COLUMN_CYCLE_TIME'(COLUMN_CYCLE_TIME - 1);
    end else if (wr_len_r != '0) begin
      wr_len_r <= wr_len_r - 1'b1;
    end
  end
  // Captured write words also pass a buffer toward the core side
  dram_fifo #(.WIDTH(DATA_W), .DEPTH(16)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(wr_due),
    .in_ready(fifo_in_ready),
    .in_data(wdata),
    .out_valid(fifo_out_valid),
    .out_ready(wr_ready),
    .out_data(fifo_out_data)
  );
  // Registered copy of the word popped on this edge; a full buffer is flagged
  // Only popped words are shown, so a stalled core never sees one word twice
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_valid_r <= 1'b0;
      wr_word_r <= '0;
      fifo_full_r <= 1'b0;
    end else begin
      wr_valid_r <= fifo_out_valid && wr_ready;
      wr_word_r <= fifo_out_data;
      fifo_full_r <= !fifo_in_ready;
    end
  end
  // Read data follows its column packet by exactly the read delay
  rd_lat_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_rd |-> ##(READ_DATA_DELAY+1) rd_valid_r)
    else $error("read data late or missing");
  // Activate opens the bank on the next edge
  act_open_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_act |=> row_open_r[$past(req_bank)])
    else $error("activate did not open bank");
  // Precharge closes the bank
  pre_close_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_pre |=> !row_open_r[$past(req_bank)])
    else $error("precharge did not close bank");
  // Write capture happens exactly at the write data slot
  wr_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_wr |-> ##(WRITE_DATA_DELAY) wr_due)
    else $error("write capture misplaced");
  // Read packet shape: valid for both cycles of the column cycle
  sequence rd_pkt_s;
    rd_valid_r [*2];
  endsequence
  rd_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_due |=> rd_pkt_s)
    else $error("read packet length wrong");
  // Write slot: capture, then the window tracker runs for the rest of the slot
  sequence wr_slot_s;
    wr_due ##1 (wr_len_r != '0);
  endsequence
  wr_slot_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_wr |-> ##(WRITE_DATA_DELAY) wr_slot_s)
    else $error("write slot wrong");
  // An open row stays open until its bank is precharged
  row_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    (row_open_r[req_bank] && !is_pre) |=> row_open_r[$past(req_bank)])
    else $error("open row lost without precharge");
endmodule : dram_seq

//--- test/dram_page_transaction_sequencing_tb_top.sv
`timescale 1ns/1ps
module dram_page_transaction_sequencing_tb_top import dram_seq_pkg::*;;
  typedef struct {logic [2:0] b; logic [11:0] r; logic [5:0] c; logic [15:0] d;} row_s;
  logic clk, rst_n, wr_ready, req_wr, rd_valid_r, wr_valid_r, fifo_full_r;
  logic [1:0] req_cmd;
  logic [2:0] req_bank;
  logic [11:0] req_row;
  logic [5:0] req_col;
  logic [15:0] wdata, rdata_r, wr_word_r;
  logic [7:0] row_open_r;
  logic [15:0] exp_q[$]; // Words the capture path still owes
  int miscompares = 0;
  int n_checks = 0;
  // Page-empty rows: bank, row, column, data written and read back
  row_s rows[4] = '{'{0, 12'h000, 0, 16'h1234}, '{3, 12'h0A5, 17, 16'hBEEF},
                    '{5, 12'h7FF, 40, 16'h0001}, '{7, 12'hFFF, 63, 16'hFFFE}};
  mc_model mc_u (.clk(clk), .req_cmd(req_cmd), .req_bank(req_bank), .req_row(req_row),
    .req_col(req_col), .req_wr(req_wr), .wdata(wdata));
  dram_seq dut_u (.clk(clk), .rst_n(rst_n), .req_cmd(req_cmd), .req_bank(req_bank),
    .req_row(req_row), .req_col(req_col), .req_wr(req_wr), .wdata(wdata),
    .rd_valid_r(rd_valid_r), .rdata_r(rdata_r), .wr_valid_r(wr_valid_r), .wr_ready(wr_ready),
    .wr_word_r(wr_word_r), .row_open_r(row_open_r), .fifo_full_r(fifo_full_r));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // Read packet must sit exactly at its slot and last a column cycle
  task automatic rd_chk(input logic [15:0] d, input bit lst);
    repeat (READ_DATA_DELAY) @(posedge clk);
    #1 chk("rd_valid", rd_valid_r, 1);
    chk("rdata", rdata_r, d);
    @(posedge clk);
    #1 chk("rd_valid2", rd_valid_r, 1);
    chk("rdata2", rdata_r, d);
    @(posedge clk);
    if (lst) #1 chk("rd_end", rd_valid_r, 0);
  endtask : rd_chk
  task automatic rd(input logic [2:0] b, input logic [5:0] c, input logic [15:0] d, bit l);
    mc_u.op(CMD_COL, b, '0, c, 0, '0);
    fork rd_chk(d, l); join_none
  endtask : rd
  task automatic wr(input logic [2:0] b, input logic [5:0] c, input logic [15:0] d);
    exp_q.push_back(d);
    mc_u.op(CMD_COL, b, '0, c, 1, d);
  endtask : wr
  // Captured words leave in order, each the word from its own slot
  always @(posedge clk) begin
    if (rst_n && wr_valid_r === 1'b1)
      chk("wr_word", wr_word_r, (exp_q.size() > 0) ? exp_q.pop_front() : ~wr_word_r);
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out();
  end
  initial begin
    rst_n = 0;
    wr_ready = 1;
    repeat (12) @(posedge clk);
    @(negedge clk) rst_n = 1;
    chk("rst_out", {rd_valid_r, wr_valid_r, fifo_full_r, row_open_r}, 0);
    // Page-empty access, closed again afterwards
    foreach (rows[i]) begin
      mc_u.op(CMD_ACT, rows[i].b, rows[i].r, '0, 0, '0);
      chk("open", row_open_r[rows[i].b], 1);
      wr(rows[i].b, rows[i].c, rows[i].d);
      wr(rows[i].b, rows[i].c ^ 6'h01, ~rows[i].d);
      repeat (3) @(negedge clk);
      rd(rows[i].b, rows[i].c, rows[i].d, 0);
      rd(rows[i].b, rows[i].c ^ 6'h01, ~rows[i].d, 1);
      mc_u.op(CMD_PRE, rows[i].b, '0, '0, 0, '0);
      #1 chk("closed", row_open_r[rows[i].b], 0);
    end
    // Page miss, then a page hit on the new row
    mc_u.op(CMD_ACT, 2, 12'h111, '0, 0, '0);
    wr(2, 5, 16'hA5A5);
    mc_u.op(CMD_PRE, 2, '0, '0, 0, '0);
    mc_u.op(CMD_ACT, 2, 12'h222, '0, 0, '0);
    wr(2, 5, 16'h5A5A);
    repeat (3) @(negedge clk);
    rd(2, 5, 16'h5A5A, 1);
    repeat (10) @(negedge clk);
    chk("hit_open", row_open_r[2], 1);
    // Capture buffer filled while the core stalls, then drained
    wr_ready = 0;
    for (int i = 0; i < 16; i++) wr(2, i[5:0], 16'h1000 + i[15:0]);
    repeat (6) @(negedge clk);
    chk("full", fifo_full_r, 1);
    wr_ready = 1;
    repeat (30) @(negedge clk);
    chk("drained", fifo_full_r, 0);
    chk("wr_left", exp_q.size(), 0);
    rd(2, 15, 16'h100F, 1);
    repeat (12) @(negedge clk);
    close_out();
  end
endmodule : dram_page_transaction_sequencing_tb_top

//--- test/mc_model.sv
`timescale 1ns/1ps
// Controller side: issues request packets and keeps every row and column spacing
module mc_model import dram_seq_pkg::*; #(
  parameter int PRE_ACT = 3, // Precharge to activate
  parameter int ACT_COL = 4, // Activate to first column, read or write
  parameter int COL_PRE = 6, // Last column to precharge
  parameter int ROW_MIN = 10 // Minimum row active span
) (
  input wire logic clk, // Request clock
  output logic [1:0] req_cmd, // Command
  output logic [2:0] req_bank, // Bank
  output logic [11:0] req_row, // Row
  output logic [5:0] req_col, // Column
  output logic req_wr, // Write flag
  output logic [15:0] wdata // Write data bus
);
  int cyc = 0; // Edges seen so far
  int t_pre = -99; // Edge of last precharge
  int t_act = -99; // Edge of last activate
  int t_col = -99; // Edge of last column packet
  int wseq = 0; // Newest write packet id
  initial begin
    {req_cmd, req_bank, req_row, req_col, req_wr, wdata} = '0;
  end
  always @(posedge clk) cyc++;
  // Data slot opens write_data_delay after the column packet and lasts a column cycle
  task automatic drive_d(input logic [15:0] d, input int id);
    repeat (WRITE_DATA_DELAY) @(negedge clk);
    wdata = d;
    repeat (COLUMN_CYCLE_TIME) @(negedge clk);
    // Released bus shows a changed value so a late capture is seen
    if (id == wseq) wdata = ~d;
  endtask : drive_d
  // One request, held back until every limit is met
  task automatic op(input cmd_e c, input logic [2:0] b, input logic [11:0] r,
                    input logic [5:0] col, input logic w, input logic [15:0] d);
    int e;
    e = 0;
    if (c == CMD_ACT) e = t_pre + PRE_ACT;
    if (c == CMD_COL) e = (t_act + ACT_COL > t_col + COLUMN_CYCLE_TIME) ?
                          t_act + ACT_COL : t_col + COLUMN_CYCLE_TIME;
    if (c == CMD_PRE) e = (t_col + COL_PRE > t_act + ROW_MIN) ?
                          t_col + COL_PRE : t_act + ROW_MIN;
    @(negedge clk);
    while (cyc + 1 < e) @(negedge clk);
    {req_cmd, req_bank, req_row, req_col, req_wr} = {c, b, r, col, w};
    if (c == CMD_ACT) t_act = cyc + 1;
    if (c == CMD_PRE) t_pre = cyc + 1;
    if (c == CMD_COL) t_col = cyc + 1;
    if (c == CMD_COL && w) begin
      wseq++;
      fork drive_d(d, wseq); join_none
    end
    @(negedge clk);
    req_cmd = CMD_NOP;
  endtask : op
endmodule : mc_model
